// ### include/plc_flag_regs.svh
// Register offsets, field positions, reset values and timing counts of the flag bank.
`ifndef PLC_FLAG_REGS_SVH
`define PLC_FLAG_REGS_SVH
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define RX_CANCEL_LO_OFFSET 12'h008
`define RX_CANCEL_HI_OFFSET 12'h00C
`define RX_ACTIVE_LO_OFFSET 12'h010
`define RX_ACTIVE_HI_OFFSET 12'h014
`define DATE_STAGE_OFFSET 12'h018
`define TIME_STAGE_OFFSET 12'h01C
`define CLOCK_DATE_OFFSET 12'h020
`define CLOCK_TIME_OFFSET 12'h024
`define CTRL_START 0
`define CTRL_ONE_SEC_RESET 1
`define CTRL_ALL_OFF 2
`define CTRL_PROHIBIT 3
`define CTRL_LINK_INIT 4
`define CTRL_LED 5
`define CTRL_DATE_WR 6
`define CTRL_TIME_WR 7
`define CTRL_DATE_TIME_WR 8
`define CTRL_SEC_ADJ 9
`define CTRL_HOLD 10
`define CTRL_UNMOUNT 11
`define CTRL_RESET_VAL 32'h0000_0000
`define NUM_PORTS 33
`define HALF_SEC_MS 500
`define LINK_LOST_S 10
`define CLK_MHZ 200
`define HALF_SEC_CYCLES (`HALF_SEC_MS * 1000 * `CLK_MHZ)
`define LINK_LOST_CYCLES (`LINK_LOST_S * 1000000 * `CLK_MHZ)
`endif

// ### include/plc_flag_pkg.sv
// Types shared by the flag bank.
package plc_flag_pkg;
  typedef enum logic [1:0] {
    CPU_STOP = 2'b00,
    CPU_RUN = 2'b01,
    CPU_HOLD = 2'b11
  } cpu_state_t;
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] weekday;
  } date_t;
  typedef struct packed {
    logic [7:0] spare;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } time_t;
  typedef struct packed {
    logic add_carry;
    logic sub_borrow;
    logic exec_error;
    logic block_busy;
  } cpu_events_t;
endpackage

// ### rtl/plc_system_flag_bank.sv
// System control and status flag bank with an APB register port.
// Operation
// R01: Start control flag set means run, clear means stop.
// R02: Function switch, stop input and reset input override start control.
// R03: Start control flag survives power-down and is restored at power-up.
// R04: One-second clock reset flag holds the one-second pulse low.
// R05: One-second pulse toggles every 500 ms while not reset.
// R06: All-outputs-off flag forces every output off, latched ones too.
// R07: Carry/borrow flag sets on add carry or subtract borrow.
// R08: Program execution error flag sets on any execution error.
// R09: Link error flag sets on link error and stays set.
// R10: Master suspends link traffic while prohibit flag is set.
// R11: Master in run re-initialises link once per init flag set.
// R12: Slave flags link lost after 10 s silence, clears on traffic.
// R13: Status LED follows the LED control flag.
// R14: Clock write/adjust error flag sets on failure, clears on success.
// R15: Clock read error flag sets on read failure, clears on success.
// R16: Write triggers load staged date, time or both into the clock.
// R17: Adjust zeroes seconds, adds a minute when seconds are 30 or more.
// R18: Each port's receive is cancelled while its cancel flag is set.
// R19: Block transfer busy flag follows block move or word shift execution.
// R20: Hold flag keeps outputs on stop and self-clears on next run.
// R21: Card mounted shows a usable card; card access shows active access.
// R22: Unmount stops card access until the card is reinserted.
// R23: Function switch status flag mirrors the front switch.
// R24: Write, adjust and link init triggers act once on rising edge.
//
// Chosen here: the address map and register access over APB.
`include "plc_flag_regs.svh"
module plc_system_flag_bank #(
  parameter int unsigned HALF_SEC_CYCLES = `HALF_SEC_CYCLES,
  parameter longint unsigned LINK_LOST_CYCLES = `LINK_LOST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic function_switch,
  input wire logic stop_input,
  input wire logic reset_input,
  input wire logic start_backup,
  input wire logic start_backup_valid,
  output logic start_backup_out,
  input wire plc_flag_pkg::cpu_events_t cpu_events,
  input wire logic link_error,
  input wire logic link_is_master,
  input wire logic link_rx_traffic,
  output logic link_suspend,
  output logic link_init_pulse,
  input wire logic clock_op_done,
  input wire logic clock_op_fail,
  input wire logic clock_read_done,
  input wire logic clock_read_fail,
  input wire logic [`NUM_PORTS-1:0] rx_active,
  output logic [`NUM_PORTS-1:0] rx_cancel,
  input wire logic card_present,
  input wire logic card_recognised,
  input wire logic card_busy,
  output logic card_access_enable,
  input wire logic [15:0] program_outputs,
  output logic [15:0] outputs,
  output logic cpu_running,
  output logic one_sec_clock_pulse,
  output logic status_led
);
  localparam logic [31:0] HALF_SEC_LAST = 32'(HALF_SEC_CYCLES - 1);
  localparam logic [40:0] LOST_LAST = 41'(LINK_LOST_CYCLES - 1);

  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic [31:0] ctrl_reg, ctrl_next;
  logic [63:0] cancel_reg, cancel_next;
  plc_flag_pkg::date_t date_stage_reg, date_stage_next, clk_date_reg, clk_date_next;
  plc_flag_pkg::time_t time_stage_reg, time_stage_next, clk_time_reg, clk_time_next;
  logic carry_reg, carry_next, exec_err_reg, exec_err_next;
  logic link_err_reg, link_err_next, lost_reg, lost_next;
  logic wr_err_reg, wr_err_next, rd_err_reg, rd_err_next;
  logic card_lock_reg, card_lock_next, card_prev_reg, card_prev_next;
  logic [4:0] edge_prev_reg, edge_prev_next;
  logic [31:0] half_cnt_reg, half_cnt_next;
  logic [40:0] lost_cnt_reg, lost_cnt_next;
  logic pulse_reg, pulse_next;
  plc_flag_pkg::cpu_state_t state_reg, state_next;
  logic [15:0] held_reg, held_next;
  logic [31:0] rdata_reg, rdata_next;
  logic restored_reg, restored_next;

  logic wr_en;
  logic rd_en;
  logic run_req;
  logic [4:0] trig_now;
  logic [4:0] trig_rise;
  logic [7:0] new_min;
  assign wr_en = psel && penable && pwrite;
  // Read data is captured in the setup cycle, so it already stands when pready is sampled.
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata_reg;

  // Run request after overrides; the switch at 0 forces stop. [R01] [R02]
  assign run_req = ctrl_reg[`CTRL_START] && function_switch && !stop_input && !reset_input;
  assign trig_now = {ctrl_reg[`CTRL_LINK_INIT], ctrl_reg[`CTRL_SEC_ADJ],
                     ctrl_reg[`CTRL_DATE_TIME_WR], ctrl_reg[`CTRL_TIME_WR],
                     ctrl_reg[`CTRL_DATE_WR]};
  assign trig_rise = trig_now & ~edge_prev_reg; // [R24]
  assign new_min = (clk_time_reg.minutes == 8'h3B) ? 8'h00 : clk_time_reg.minutes + 8'h01;

  always_comb begin
    ctrl_next = ctrl_reg;
    cancel_next = cancel_reg;
    date_stage_next = date_stage_reg;
    time_stage_next = time_stage_reg;
    restored_next = 1'b1;
    // The backup copy is taken once after reset release; a live port cannot feed reset. [R03]
    if (!restored_reg && start_backup_valid) begin
      ctrl_next[`CTRL_START] = start_backup;
    end
    if (wr_en) begin
      case (paddr)
        `CTRL_OFFSET: ctrl_next = pwdata;
        `RX_CANCEL_LO_OFFSET: cancel_next[31:0] = pwdata;
        `RX_CANCEL_HI_OFFSET: cancel_next[63:32] = pwdata;
        `DATE_STAGE_OFFSET: date_stage_next = pwdata;
        `TIME_STAGE_OFFSET: time_stage_next = pwdata;
        default: ;
      endcase
    end
    // Hold flag clears itself on the return to run. [R20]
    if (state_reg != plc_flag_pkg::CPU_RUN && run_req) begin
      ctrl_next[`CTRL_HOLD] = 1'b0;
    end
    ctrl_next[31:12] = 20'h0_0000;
    cancel_next[63:`NUM_PORTS] = '0;
  end

  always_comb begin
    clk_date_next = clk_date_reg;
    clk_time_next = clk_time_reg;
    wr_err_next = wr_err_reg;
    rd_err_next = rd_err_reg;
    // Date, time or both staged values load on a trigger edge. [R16]
    if (trig_rise[0] || trig_rise[2]) begin
      clk_date_next = date_stage_reg;
    end
    if (trig_rise[1] || trig_rise[2]) begin
      clk_time_next = time_stage_reg;
    end
    // Seconds zero; minute rounds up from 30 seconds on. [R17]
    if (trig_rise[3]) begin
      clk_time_next.seconds = 8'h00;
      if (clk_time_reg.seconds >= 8'h1E) begin
        clk_time_next.minutes = new_min;
      end
    end
    if (clock_op_done) begin
      wr_err_next = 1'b0; // [R14]
    end
    if (clock_op_fail) begin
      wr_err_next = 1'b1; // [R14]
    end
    if (clock_read_done) begin
      rd_err_next = 1'b0; // [R15]
    end
    if (clock_read_fail) begin
      rd_err_next = 1'b1; // [R15]
    end
  end

  // Status write with a 0 bit clears sticky flags; hardware set wins. [R07] [R08] [R09]
  always_comb begin
    carry_next = carry_reg;
    exec_err_next = exec_err_reg;
    link_err_next = link_err_reg;
    if (wr_en && paddr == `STATUS_OFFSET) begin
      carry_next = pwdata[0];
      exec_err_next = pwdata[1];
      link_err_next = pwdata[2];
    end
    if (cpu_events.add_carry || cpu_events.sub_borrow) begin
      carry_next = 1'b1;
    end
    if (cpu_events.exec_error) begin
      exec_err_next = 1'b1;
    end
    if (link_error) begin
      link_err_next = 1'b1;
    end
  end

  // Slave silence timer; master role keeps it idle. [R12]
  always_comb begin
    lost_cnt_next = lost_cnt_reg;
    lost_next = lost_reg;
    if (link_is_master || link_rx_traffic) begin
      lost_cnt_next = '0;
      lost_next = 1'b0;
    end else if (lost_cnt_reg == LOST_LAST) begin
      lost_next = 1'b1;
    end else begin
      lost_cnt_next = lost_cnt_reg + 41'd1;
    end
  end

  // Half-second divider; reset flag holds the pulse low. [R04] [R05]
  always_comb begin
    half_cnt_next = half_cnt_reg + 32'd1;
    pulse_next = pulse_reg;
    if (ctrl_reg[`CTRL_ONE_SEC_RESET]) begin
      half_cnt_next = '0;
      pulse_next = 1'b0;
    end else if (half_cnt_reg == HALF_SEC_LAST) begin
      half_cnt_next = '0;
      pulse_next = !pulse_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    held_next = held_reg;
    case (state_reg)
      plc_flag_pkg::CPU_STOP: begin
        if (run_req) state_next = plc_flag_pkg::CPU_RUN;
      end
      plc_flag_pkg::CPU_RUN: begin
        held_next = program_outputs;
        if (!run_req) begin
          state_next = ctrl_reg[`CTRL_HOLD] ? plc_flag_pkg::CPU_HOLD : plc_flag_pkg::CPU_STOP;
        end
      end
      plc_flag_pkg::CPU_HOLD: begin
        if (run_req) state_next = plc_flag_pkg::CPU_RUN;
      end
      default: state_next = plc_flag_pkg::CPU_STOP;
    endcase
  end

  // Unmount locks the card until it has been pulled and inserted again. [R22]
  always_comb begin
    card_prev_next = card_present;
    card_lock_next = card_lock_reg;
    if (card_present && !card_prev_reg) begin
      card_lock_next = 1'b0;
    end
    if (ctrl_reg[`CTRL_UNMOUNT]) begin
      card_lock_next = 1'b1;
    end
    edge_prev_next = trig_now;
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (rd_en) begin
      case (paddr)
        `CTRL_OFFSET: rdata_next = ctrl_reg;
        // Card and switch flags are live status views. [R21] [R23]
        `STATUS_OFFSET: rdata_next = {20'h0_0000, function_switch,
                                      card_busy && card_access_enable,
                                      card_recognised && card_present && !card_lock_reg,
                                      cpu_events.block_busy, lost_reg, rd_err_reg,
                                      wr_err_reg, pulse_reg, state_reg == plc_flag_pkg::CPU_RUN,
                                      link_err_reg, exec_err_reg, carry_reg}; // [R19]
        `RX_CANCEL_LO_OFFSET: rdata_next = cancel_reg[31:0];
        `RX_CANCEL_HI_OFFSET: rdata_next = cancel_reg[63:32];
        `RX_ACTIVE_LO_OFFSET: rdata_next = rx_active[31:0];
        `RX_ACTIVE_HI_OFFSET: rdata_next = {31'h0000_0000, rx_active[32]};
        `DATE_STAGE_OFFSET: rdata_next = 32'h0000_0000;
        `TIME_STAGE_OFFSET: rdata_next = 32'h0000_0000;
        `CLOCK_DATE_OFFSET: rdata_next = clk_date_reg;
        `CLOCK_TIME_OFFSET: rdata_next = clk_time_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ctrl_reg <= `CTRL_RESET_VAL;
      cancel_reg <= '0;
      date_stage_reg <= '0;
      time_stage_reg <= '0;
      clk_date_reg <= '0;
      clk_time_reg <= '0;
      carry_reg <= 1'b0;
      exec_err_reg <= 1'b0;
      link_err_reg <= 1'b0;
      lost_reg <= 1'b0;
      wr_err_reg <= 1'b0;
      rd_err_reg <= 1'b0;
      card_lock_reg <= 1'b0;
      card_prev_reg <= 1'b0;
      edge_prev_reg <= '0;
      half_cnt_reg <= '0;
      lost_cnt_reg <= '0;
      pulse_reg <= 1'b0;
      state_reg <= plc_flag_pkg::CPU_STOP;
      held_reg <= '0;
      rdata_reg <= '0;
      restored_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      cancel_reg <= cancel_next;
      date_stage_reg <= date_stage_next;
      time_stage_reg <= time_stage_next;
      clk_date_reg <= clk_date_next;
      clk_time_reg <= clk_time_next;
      carry_reg <= carry_next;
      exec_err_reg <= exec_err_next;
      link_err_reg <= link_err_next;
      lost_reg <= lost_next;
      wr_err_reg <= wr_err_next;
      rd_err_reg <= rd_err_next;
      card_lock_reg <= card_lock_next;
      card_prev_reg <= card_prev_next;
      edge_prev_reg <= edge_prev_next;
      half_cnt_reg <= half_cnt_next;
      lost_cnt_reg <= lost_cnt_next;
      pulse_reg <= pulse_next;
      state_reg <= state_next;
      held_reg <= held_next;
      rdata_reg <= rdata_next;
      restored_reg <= restored_next;
    end
  end

  // Per-port cancel view, one lane per port. [R18]
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PORTS; gi++) begin : g_port
      assign rx_cancel[gi] = cancel_reg[gi] && rx_active[gi];
    end
  endgenerate

  // Outputs: forced off, live in run, held in hold state, off in stop. [R06] [R20]
  always_comb begin
    if (ctrl_reg[`CTRL_ALL_OFF]) begin
      outputs = 16'h0000;
    end else if (state_reg == plc_flag_pkg::CPU_RUN) begin
      outputs = program_outputs;
    end else if (state_reg == plc_flag_pkg::CPU_HOLD) begin
      outputs = held_reg;
    end else begin
      outputs = 16'h0000;
    end
  end

  assign cpu_running = (state_reg == plc_flag_pkg::CPU_RUN); // [R01]
  assign one_sec_clock_pulse = pulse_reg;
  assign status_led = ctrl_reg[`CTRL_LED]; // [R13]
  assign start_backup_out = ctrl_reg[`CTRL_START]; // [R03]
  assign link_suspend = link_is_master && ctrl_reg[`CTRL_PROHIBIT]; // [R10]
  // One init per rising edge, only as master in run. [R11] [R24]
  assign link_init_pulse = trig_rise[4] && link_is_master && cpu_running;
  assign card_access_enable = card_present && card_recognised && !card_lock_reg; // [R22]

  a_pulse_reset_low: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg) // [R04]
    ctrl_reg[`CTRL_ONE_SEC_RESET] |=> !one_sec_clock_pulse) else $error("pulse not low");
  a_link_err_sticky: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg) // [R09]
    link_error |=> link_err_reg) else $error("link error not set");
  a_all_off_outputs: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg) // [R06]
    ctrl_reg[`CTRL_ALL_OFF] |-> outputs == 16'h0000) else $error("outputs not off");
  a_prohibit_suspend: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg) // [R10]
    (link_is_master && ctrl_reg[`CTRL_PROHIBIT]) |-> link_suspend) else $error("no suspend");
  a_init_single: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg) // [R11]
    link_init_pulse |=> !link_init_pulse) else $error("init repeated");
  a_override_stop: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg) // [R02]
    (stop_input || reset_input || !function_switch) |=> !cpu_running) else $error("ran");
  a_adjust_zero: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg) // [R17]
    trig_rise[3] |=> clk_time_reg.seconds == 8'h00) else $error("seconds not zero");
  a_carry_set: assert property (@(posedge sys_clk) disable iff (!rst_sync_reg) // [R07]
    cpu_events.add_carry |=> carry_reg) else $error("carry not set");
  c_run_stop: cover property (@(posedge sys_clk) cpu_running ##1 !cpu_running);
  c_hold_entry: cover property (@(posedge sys_clk) state_reg == plc_flag_pkg::CPU_HOLD);
  c_link_lost: cover property (@(posedge sys_clk) lost_reg);
endmodule

// ### dv/plc_system_flag_bank_tb.sv
// Self-checking bench for the system flag bank, driven over APB.
`include "plc_flag_regs.svh"
module plc_system_flag_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HS = 4;
  localparam int LL = 10;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, m_ctrl, m_st, v;
  logic function_switch, stop_input, reset_input, start_backup, start_backup_valid;
  logic start_backup_out, link_error, link_is_master, link_rx_traffic, link_suspend;
  logic link_init_pulse, clock_op_done, clock_op_fail, clock_read_done, clock_read_fail;
  logic card_present, card_recognised, card_busy, card_access_enable;
  logic cpu_running, one_sec_clock_pulse, status_led;
  logic [`NUM_PORTS-1:0] rx_active, rx_cancel, m_cancel;
  logic [15:0] program_outputs, outputs, held;
  logic [9:0] evs;
  plc_flag_pkg::cpu_events_t cpu_events;
  int failures, total_checks, n, inits;

  // Event pulses share one vector; bit 0 is the block-busy level and is kept across pulses.
  assign {link_error, link_rx_traffic, clock_op_done, clock_op_fail, clock_read_done,
          clock_read_fail, cpu_events} = evs;

  plc_system_flag_bank #(.HALF_SEC_CYCLES(HS), .LINK_LOST_CYCLES(LL)) dut_u (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .function_switch, .stop_input, .reset_input, .start_backup, .start_backup_valid,
    .start_backup_out, .cpu_events, .link_error, .link_is_master, .link_rx_traffic,
    .link_suspend, .link_init_pulse, .clock_op_done, .clock_op_fail, .clock_read_done,
    .clock_read_fail, .rx_active, .rx_cancel, .card_present, .card_recognised, .card_busy,
    .card_access_enable, .program_outputs, .outputs, .cpu_running, .one_sec_clock_pulse,
    .status_led
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (link_init_pulse === 1'b1) begin
      inits++;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] st_exp();
    logic run;
    run = m_ctrl[`CTRL_START] & function_switch & ~stop_input & ~reset_input;
    return (m_st & 32'h0000_00e7) | {20'h0_0000, function_switch, card_busy,
      card_present & card_recognised, cpu_events.block_busy, 4'h0, run, 3'h0};
  endfunction

  task automatic check(string nm, logic [63:0] e, logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Read data is taken at the edge at which pready ends the access phase.
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask

  task automatic wctrl(logic [31:0] d);
    m_ctrl = d;
    apb(1'b1, `CTRL_OFFSET, d);
    tick(1);
  endtask

  task automatic rdchk(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, e, rd);
  endtask

  task automatic stchk();
    apb(1'b0, `STATUS_OFFSET, 32'h0000_0000);
    check("status", st_exp(), rd & 32'hffff_ffef);
  endtask

  task automatic pulse(int k);
    @(posedge sys_clk);
    evs <= (evs & 10'h001) | (10'h001 << k);
    @(posedge sys_clk);
    evs <= evs & 10'h001;
    tick(2);
  endtask

  task automatic done(string nm);
    $display("test %s done", nm);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    $display("watchdog expired");
    failures++;
    results();
  end

  initial begin
    seed = 32'hd3d9_71bb;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    function_switch = 1'b1;
    stop_input = 1'b0;
    reset_input = 1'b0;
    start_backup = 1'b1;
    start_backup_valid = 1'b1;
    evs = 10'h000;
    link_is_master = 1'b1;
    rx_active = '0;
    card_present = 1'b0;
    card_recognised = 1'b0;
    card_busy = 1'b0;
    program_outputs = 16'h0000;
    m_st = 32'h0000_0000;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(4);
    @(posedge sys_clk);
    start_backup_valid <= 1'b0;
    m_ctrl = 32'h0000_0001;
    rdchk("ctrl restored", `CTRL_OFFSET, m_ctrl);
    check("running", 1, cpu_running);
    check("backup out", 1, start_backup_out);
    stchk();
    rdchk("unmapped", 12'h100, 32'h0000_0000);
    check("no slave error", 0, pslverr);
    done("restore");
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      function_switch <= (i != 0);
      stop_input <= (i == 1);
      reset_input <= (i == 2);
      tick(3);
      check("override", 0, cpu_running);
      stchk();
      @(posedge sys_clk);
      function_switch <= 1'b1;
      stop_input <= 1'b0;
      reset_input <= 1'b0;
      tick(3);
      check("resume", 1, cpu_running);
    end
    wctrl(32'h0000_0000);
    check("stop", 0, cpu_running);
    done("run control");
    @(posedge sys_clk);
    program_outputs <= 16'(rnd());
    wctrl(32'h0000_0021);
    check("led on", 1, status_led);
    check("outputs run", program_outputs, outputs);
    wctrl(32'h0000_0025);
    check("outputs killed", 0, outputs);
    wctrl(32'h0000_0401);
    check("led off", 0, status_led);
    held = program_outputs;
    @(posedge sys_clk);
    stop_input <= 1'b1;
    tick(3);
    @(posedge sys_clk);
    program_outputs <= 16'(rnd());
    tick(2);
    check("outputs held", held, outputs);
    @(posedge sys_clk);
    stop_input <= 1'b0;
    tick(3);
    rdchk("hold cleared", `CTRL_OFFSET, 32'h0000_0001);
    done("outputs");
    wctrl(32'h0000_0003);
    n = 0;
    repeat (20) begin
      tick(1);
      n += (one_sec_clock_pulse !== 1'b0);
    end
    check("pulse in reset", 0, n);
    wctrl(32'h0000_0001);
    n = 0;
    while (one_sec_clock_pulse !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    for (int b = 1; b >= 0; b--) begin
      n = 0;
      while (one_sec_clock_pulse === b[0] && n < 20) begin
        tick(1);
        n++;
      end
      check("pulse phase", HS, n);
    end
    done("one second");
    pulse(3);
    m_st = 32'h0000_0001;
    stchk();
    apb(1'b1, `STATUS_OFFSET, 32'h0000_0000);
    m_st = 32'h0000_0000;
    stchk();
    pulse(2);
    pulse(1);
    pulse(9);
    m_st = 32'h0000_0007;
    tick(5);
    stchk();
    apb(1'b1, `STATUS_OFFSET, 32'h0000_0000);
    m_st = 32'h0000_0000;
    pulse(6);
    pulse(4);
    m_st = 32'h0000_0060;
    stchk();
    pulse(7);
    pulse(5);
    m_st = 32'h0000_0000;
    stchk();
    done("status");
    wctrl(32'h0000_0009);
    check("suspend", 1, link_suspend);
    inits = 0;
    wctrl(32'h0000_0011);
    check("suspend off", 0, link_suspend);
    wctrl(32'h0000_0011);
    tick(10);
    check("init once", 1, inits);
    wctrl(32'h0000_0001);
    @(posedge sys_clk);
    link_is_master <= 1'b0;
    tick(LL + 5);
    m_st = 32'h0000_0080;
    stchk();
    pulse(8);
    m_st = 32'h0000_0000;
    stchk();
    // Back to master, or the silence timer would raise the lost flag in later status reads.
    @(posedge sys_clk);
    link_is_master <= 1'b1;
    done("link");
    apb(1'b1, `DATE_STAGE_OFFSET, 32'h1806_1503);
    wctrl(32'h0000_0041);
    rdchk("clock date", `CLOCK_DATE_OFFSET, 32'h1806_1503);
    // Seconds 1 and 59 sit on either side of the half-minute.
    for (int i = 0; i < 2; i++) begin
      v = {8'h00, 8'h0c, 8'h05, (i == 0) ? 8'h01 : 8'h3b};
      apb(1'b1, `TIME_STAGE_OFFSET, v);
      apb(1'b1, `DATE_STAGE_OFFSET, 32'h1806_1503 + i);
      wctrl(32'h0000_0001);
      wctrl((i == 0) ? 32'h0000_0081 : 32'h0000_0101);
      wctrl(32'h0000_0201);
      rdchk("date load", `CLOCK_DATE_OFFSET, 32'h1806_1503 + i);
      apb(1'b0, `CLOCK_TIME_OFFSET, 32'h0000_0000);
      check("hour minute", {8'h0c, 8'h05 + 8'(i)}, rd[23:8]);
      check("seconds zeroed", 8'h00, rd[7:0]);
    end
    done("clock");
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      rx_active <= 33'({rnd(), rnd()});
      m_cancel[31:0] = rnd();
      m_cancel[32] = m_cancel[i];
      apb(1'b1, `RX_CANCEL_LO_OFFSET, m_cancel[31:0]);
      apb(1'b1, `RX_CANCEL_HI_OFFSET, {31'h7fff_ffff, m_cancel[32]});
      check("cancel", m_cancel & rx_active, rx_cancel);
      rdchk("cancel hi", `RX_CANCEL_HI_OFFSET, {31'h0000_0000, m_cancel[32]});
    end
    done("receive cancel");
    @(posedge sys_clk);
    card_present <= 1'b1;
    card_recognised <= 1'b1;
    card_busy <= 1'b1;
    evs <= 10'h001;
    tick(2);
    stchk();
    check("card enable", 1, card_access_enable);
    wctrl(32'h0000_0801);
    check("unmounted", 0, card_access_enable);
    wctrl(32'h0000_0001);
    check("still unmounted", 0, card_access_enable);
    @(posedge sys_clk);
    card_present <= 1'b0;
    card_busy <= 1'b0;
    evs <= 10'h000;
    tick(3);
    stchk();
    @(posedge sys_clk);
    card_present <= 1'b1;
    tick(3);
    check("reinserted", 1, card_access_enable);
    done("card");
    results();
  end
endmodule
